// ---- verif/cdo_target_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Two daisy-chained targets and the shared lines
// ==========================================================
module cdo_target_model (
  input  wire logic        cclk_in,    // Config clock
  input  wire logic [7:0]  data_in,    // Data lines
  input  wire logic        oe_in,      // Block pulls status low
  input  wire logic        err_in,     // A target flags an error
  input  wire logic        answer_in,  // Let done go when full
  input  wire logic [15:0] need_in,    // Clocks in the image
  output logic             status_out, // Status line level
  output logic             done_out    // Done line level
);
  logic [7:0] smp [$];          // Every sampled word
  int         cnt = 0;          // Clocks taken
  logic       chain_enable_out_n; // First target hands over
  // Latch on rising clock
  always @(posedge cclk_in) begin
    smp.push_back(data_in);
    cnt++;
  end
  // First target hands on at half way
  assign chain_enable_out_n = cnt < 32'(need_in) / 2;
  // Open drain: low while anyone pulls
  assign status_out = !(oe_in || err_in);
  // Done freed once both are full
  assign done_out = answer_in && cnt >= 32'(need_in) && !chain_enable_out_n;
endmodule
`default_nettype wire

// ---- verif/cdo_unit_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module cdo_unit_bench;
  import cdo_pkg::*;
  // ==========================================================
  // Stimulus and observed lines
  // ==========================================================
  localparam int DW = 4;             // Short done timeout
  logic        core_clk_in = 1'b0;   // Core clock
  logic        link_clk_in = 1'b0;   // Link clock
  logic        rst_b_in = 1'b0;      // Core reset, low
  logic        link_rst_b_in = 1'b0; // Link reset, low
  logic        ce_in = 1'b1;         // Core enable
  logic        opt_byte_mode_in = 1'b0;
  logic [1:0]  opt_width_in = 2'h0;
  logic [7:0]  word_in = 8'h00;
  logic        word_valid_in = 1'b0;
  logic        last_word_in = 1'b0;
  logic        err_in = 1'b0;        // Target error
  logic        answer_in = 1'b1;     // Target lets done go
  logic [15:0] need_in = 16'h0;      // Image clocks
  wire logic   word_ready_out, status_in, status_oe_out, done_in, config_clock_out, busy_out;
  wire logic [7:0] data_out;
  int          error_cnt = 0;
  int          checks_done = 0;
  // Unrelated clock periods
  always #5 core_clk_in = ~core_clk_in;
  always #7.5 link_clk_in = ~link_clk_in;
  cdo_unit #(.DONE_WAIT(DW)) u_dut (
    .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in), .link_clk_in(link_clk_in),
    .link_rst_b_in(link_rst_b_in), .opt_byte_mode_in(opt_byte_mode_in), .opt_width_in(opt_width_in),
    .word_in(word_in), .word_valid_in(word_valid_in), .word_ready_out(word_ready_out),
    .last_word_in(last_word_in), .status_in(status_in), .status_oe_out(status_oe_out), .status_out(),
    .done_in(done_in), .config_clock_out(config_clock_out), .data_out(data_out), .busy_out(busy_out));
  cdo_target_model u_tgt (.cclk_in(config_clock_out), .data_in(data_out), .oe_in(status_oe_out),
    .err_in(err_in), .answer_in(answer_in), .need_in(need_in), .status_out(status_in), .done_out(done_in));
  // ==========================================================
  // Shared tasks
  // ==========================================================
  task automatic stop_test();
    if (error_cnt == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tmo();
    error_cnt++;
    $display("MISMATCH wait expected event seen none");
    stop_test();
  endtask
  // Reset both domains, clear target record
  task automatic do_reset(input logic bm, input logic [1:0] w, input int need, input logic ans);
    @(posedge core_clk_in);
    rst_b_in <= 1'b0;
    link_rst_b_in <= 1'b0;
    err_in <= 1'b0;
    opt_byte_mode_in <= bm;
    opt_width_in <= w;
    need_in <= 16'(need);
    answer_in <= ans;
    repeat (5) @(posedge core_clk_in);
    u_tgt.cnt = 0;
    u_tgt.smp.delete();
    rst_b_in <= 1'b1;
    link_rst_b_in <= 1'b1;
    @(posedge core_clk_in);
  endtask
  // Ready sampled at falling edge
  task automatic send(input logic [7:0] d, input logic lst);
    int t;
    word_in <= d;
    last_word_in <= lst;
    word_valid_in <= 1'b1;
    for (t = 0; t < 200; t++) begin
      @(negedge core_clk_in);
      if (word_ready_out === 1'b1) break;
    end
    @(posedge core_clk_in);
    word_valid_in <= 1'b0;
    last_word_in <= 1'b0;
    if (t == 200) tmo();
  endtask
  task automatic wait_idle();
    int t;
    for (t = 0; t < 3000 && data_out !== 8'hff; t++) @(negedge link_clk_in);
    if (t == 3000) tmo();
    repeat (3) @(negedge link_clk_in);
    check("idle data", 16'(data_out), 16'h00ff);
    check("idle clock", 16'(config_clock_out), 16'h0000);
  endtask
  // Gaps pause the clock; options move mid-image
  task automatic run_image(input logic bm, input logic [1:0] w, input int nw);
    logic [7:0] wd [3];
    logic [7:0] e;
    int         n, s, k;
    wd = '{8'ha5, 8'h3c, 8'hd2};
    n = bm ? 8 : (1 << w);
    s = 8 / n;
    do_reset(bm, w, nw * s, 1'b1);
    for (k = 0; k < nw; k++) begin
      send(wd[k], k == nw - 1);
      repeat (40) @(posedge core_clk_in);
      opt_width_in <= ~w;
      opt_byte_mode_in <= ~bm;
    end
    wait_idle();
    for (k = 0; k < nw * s; k++) begin
      e = 8'((wd[k / s] >> ((k % s) * n)) & ((9'h001 << n) - 9'h001));
      check("lane bits", 16'(u_tgt.smp[k]), 16'(e));
    end
  endtask
  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic s_widths();
    int w;
    for (w = 0; w < 4; w++) run_image(1'b0, 2'(w), 2);
  endtask
  task automatic s_byte();
    run_image(1'b1, 2'h0, 3);
  endtask
  // Targets busy: buffer fills, then drains
  task automatic s_gate_fill();
    int k, c;
    do_reset(1'b1, 2'h0, FIFO_DEPTH, 1'b1);
    err_in <= 1'b1;
    ce_in <= 1'b0;
    word_valid_in <= 1'b1;
    @(negedge core_clk_in);
    check("frozen ready", 16'(word_ready_out), 16'h0000);
    @(posedge core_clk_in);
    ce_in <= 1'b1;
    c = 0;
    for (k = 0; k < FIFO_DEPTH + 2; k++) begin
      word_in <= 8'(8'h10 + k);
      last_word_in <= (k == FIFO_DEPTH - 1);
      @(negedge core_clk_in);
      if (word_ready_out !== 1'b1) break;
      c++;
      @(posedge core_clk_in);
    end
    @(posedge core_clk_in);
    word_valid_in <= 1'b0;
    last_word_in <= 1'b0;
    check("words held", 16'(c), 16'(FIFO_DEPTH));
    check("held clocks", 16'(u_tgt.cnt), 16'h0000);
    err_in <= 1'b0;
    wait_idle();
    for (k = 0; k < FIFO_DEPTH; k++) check("byte", 16'(u_tgt.smp[k]), 16'(8'h10 + k));
  endtask
  // Target error stops the clock
  task automatic s_abort();
    int t, a;
    do_reset(1'b0, 2'h0, 8, 1'b1);
    send(8'h5a, 1'b1);
    for (t = 0; t < 500 && u_tgt.cnt < 3; t++) @(posedge core_clk_in);
    if (t == 500) tmo();
    check("busy", 16'(busy_out), 16'h0001);
    err_in <= 1'b1;
    repeat (10) @(posedge link_clk_in);
    @(posedge core_clk_in);
    a = u_tgt.cnt;
    repeat (20) @(posedge core_clk_in);
    check("stopped clocks", 16'(u_tgt.cnt), 16'(a));
    check("stopped early", 16'(a < 8), 16'h0001);
  endtask
  // Done held low: status pulse
  task automatic s_timeout();
    int t, r;
    do_reset(1'b0, 2'h3, 1, 1'b0);
    send(8'hc3, 1'b1);
    for (t = 0; t < 2000 && status_oe_out !== 1'b1; t++) @(negedge link_clk_in);
    if (t == 2000) tmo();
    r = u_tgt.cnt - 1;
    check("eight lanes", 16'(u_tgt.smp[0]), 16'h00c3);
    check("done wait", 16'(r >= DW && r <= DW + 1), 16'h0001);
  endtask
  initial begin
    @(posedge core_clk_in);
    s_widths();
    s_byte();
    s_gate_fill();
    s_abort();
    s_timeout();
    stop_test();
  end
endmodule
`default_nettype wire

// ---- verif/cdo_unit_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module cdo_unit_checker
  import cdo_pkg::*;
#(
  parameter int WIDTH     = DATA_W,        // Data lines
  parameter int DONE_WAIT = DONE_WAIT_CLKS // Done release timeout
) (
  input wire logic             core_clk_in,      // Core clock
  input wire logic             rst_b_in,         // Core reset, low
  input wire logic             ce_in,            // Core enable
  input wire logic             link_clk_in,      // Link clock
  input wire logic             link_rst_b_in,    // Link reset, low
  input wire logic             opt_byte_mode_in, // Byte option
  input wire logic [1:0]       opt_width_in,     // Width option
  input wire logic             word_ready_out,   // Word accepted
  input wire logic             status_in,        // Status line level
  input wire logic             status_oe_out,    // Status pull
  input wire logic             done_in,          // Done line level
  input wire logic             config_clock_out, // Config clock
  input wire logic [WIDTH-1:0] data_out          // Data lines
);
  // ==========================================================
  // Helper state
  // ==========================================================
  logic [WIDTH-1:0] lane_mask; // Lanes in use, taken at reset
  logic [15:0]      hi_cnt;    // Clock-high cycles since restart
  // Lanes fixed at reset
  always_ff @(posedge link_clk_in) begin
    if (!link_rst_b_in) begin
      lane_mask <= opt_byte_mode_in ? '1 : WIDTH'((16'h1 << (4'h1 << opt_width_in)) - 16'h1);
    end
  end
  // Counts data clocks too: floor only
  always_ff @(posedge link_clk_in) begin
    if (!link_rst_b_in || done_in || !status_in) begin
      hi_cnt <= 16'h0;
    end else if (config_clock_out) begin
      hi_cnt <= hi_cnt + 16'h1;
    end
  end
  // ==========================================================
  // Properties
  // ==========================================================
  property p_clk_high_one;
    @(posedge link_clk_in) disable iff (!link_rst_b_in) $rose(config_clock_out) |=> !config_clock_out;
  endproperty
  a_clk_high_one: assert property (p_clk_high_one) else $error("clock high too long");
  property p_data_stable;
    @(posedge link_clk_in) disable iff (!link_rst_b_in) config_clock_out |-> $stable(data_out);
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("data moved at rise");
  property p_unused_low;
    @(posedge link_clk_in) disable iff (!link_rst_b_in) config_clock_out |-> (data_out & ~lane_mask) == '0;
  endproperty
  a_unused_low: assert property (p_unused_low) else $error("unused lane not low");
  property p_stop_err;
    @(posedge link_clk_in) disable iff (!link_rst_b_in) !status_in [*7] |-> !config_clock_out;
  endproperty
  a_stop_err: assert property (p_stop_err) else $error("clock with status low");
  property p_err_pulse;
    @(posedge link_clk_in) disable iff (!link_rst_b_in) $rose(status_oe_out) |-> status_oe_out [*4] ##1 !status_oe_out;
  endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("pulse width wrong");
  property p_wait_floor;
    @(posedge link_clk_in) disable iff (!link_rst_b_in) $rose(status_oe_out) |-> hi_cnt >= DONE_WAIT;
  endproperty
  a_wait_floor: assert property (p_wait_floor) else $error("pulse too early");
  property p_idle_done;
    @(posedge link_clk_in) disable iff (!link_rst_b_in)
      $rose(done_in) ##1 done_in [*8] |-> data_out == WIDTH'(IDLE_DATA) && !config_clock_out;
  endproperty
  a_idle_done: assert property (p_idle_done) else $error("not idle after done");
  property p_ready_ce;
    @(posedge core_clk_in) disable iff (!rst_b_in) !ce_in |-> !word_ready_out;
  endproperty
  a_ready_ce: assert property (p_ready_ce) else $error("ready while frozen");
  c_pulse: cover property (@(posedge link_clk_in) $rose(status_oe_out));
  c_done: cover property (@(posedge link_clk_in) $rose(done_in));
  c_byte: cover property (@(posedge link_clk_in) opt_byte_mode_in && $rose(config_clock_out));
endmodule
bind cdo_unit cdo_unit_checker #(.WIDTH(WIDTH), .DONE_WAIT(DONE_WAIT)) u_chk (
  .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in), .link_clk_in(link_clk_in),
  .link_rst_b_in(link_rst_b_in), .opt_byte_mode_in(opt_byte_mode_in), .opt_width_in(opt_width_in),
  .word_ready_out(word_ready_out), .status_in(status_in), .status_oe_out(status_oe_out), .done_in(done_in),
  .config_clock_out(config_clock_out), .data_out(data_out)
);
`default_nettype wire

// ---- verilog/cdo_fifo.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Dual clock FIFO with gray pointers
// ==========================================================
module cdo_fifo #(
  parameter int WIDTH = 8,   // Word width
  parameter int DEPTH = 8    // Words, power of two
) (
  input  wire logic wr_clk_in,   // Write side clock
  input  wire logic wr_rst_b_in, // Write side reset, low
  input  wire logic wr_ce_in,    // Write side enable
  input  wire logic rd_clk_in,   // Read side clock
  input  wire logic rd_rst_b_in, // Read side reset, low
  cdo_stream_if.snk wr,          // Filling side
  cdo_stream_if.src rd           // Draining side
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];               // Storage
  logic [AW:0]      wr_bin, rd_bin;            // Binary pointers
  logic [AW:0]      wr_gray, rd_gray;          // Gray pointers
  logic [AW:0]      rg_s1, rg_s2, wg_s1, wg_s2; // Synchronisers

  function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  // ==========================================================
  // Write side
  // ==========================================================
  // Full when gray pointers differ only in the two top bits
  assign wr.ready = (wr_gray != {~rg_s2[AW:AW-1], rg_s2[AW-2:0]});

  always_ff @(posedge wr_clk_in) begin
    if (!wr_rst_b_in) begin
      wr_bin  <= '0;
      wr_gray <= '0;
    end else if (wr_ce_in && wr.valid && wr.ready) begin
      mem[wr_bin[AW-1:0]] <= wr.data;
      wr_bin  <= wr_bin + 1'b1;
      wr_gray <= bin2gray(wr_bin + 1'b1);
    end
  end

  // Read pointer into write domain
  always_ff @(posedge wr_clk_in) begin
    if (!wr_rst_b_in) begin
      rg_s1 <= '0;
      rg_s2 <= '0;
    end else begin
      rg_s1 <= rd_gray;
      rg_s2 <= rg_s1;
    end
  end

  // ==========================================================
  // Read side
  // ==========================================================
  assign rd.valid = (rd_gray != wg_s2);
  assign rd.data  = mem[rd_bin[AW-1:0]];

  always_ff @(posedge rd_clk_in) begin
    if (!rd_rst_b_in) begin
      rd_bin  <= '0;
      rd_gray <= '0;
    end else if (rd.valid && rd.ready) begin
      rd_bin  <= rd_bin + 1'b1;
      rd_gray <= bin2gray(rd_bin + 1'b1);
    end
  end

  // Write pointer into read domain
  always_ff @(posedge rd_clk_in) begin
    if (!rd_rst_b_in) begin
      wg_s1 <= '0;
      wg_s2 <= '0;
    end else begin
      wg_s1 <= wr_gray;
      wg_s2 <= wg_s1;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/cdo_pkg.sv ----
package cdo_pkg;
  // ==========================================================
  // Output modes
  // ==========================================================
  typedef enum logic [1:0] {
    CDO_MODE_BYTE,    // Byte parallel, eight bits per clock
    CDO_MODE_SERIAL   // Serial, n chains of one bit each
  } cdo_mode_e;

  // ==========================================================
  // Mode option encoding (stored option bits)
  // ==========================================================
  localparam logic       OPT_MODE_BYTE   = 1'b1;   // Option bit value for byte parallel
  localparam logic [1:0] OPT_WIDTH_1     = 2'h0;   // One chain
  localparam logic [1:0] OPT_WIDTH_2     = 2'h1;   // Two chains
  localparam logic [1:0] OPT_WIDTH_4     = 2'h2;   // Four chains
  localparam logic [1:0] OPT_WIDTH_8     = 2'h3;   // Eight chains

  // ==========================================================
  // Data bus and timing
  // ==========================================================
  localparam int         DATA_W          = 8;      // Data lines to targets
  localparam int         FIFO_DEPTH      = 8;      // Words buffered ahead of the link
  localparam int         DONE_WAIT_CLKS  = 64;     // Config clocks allowed for done release
  localparam int         ERR_PULSE_CLKS  = 4;      // Link cycles the status line is pulled low
  localparam logic [7:0] IDLE_DATA       = 8'hff;  // Data lines after completion

  // ==========================================================
  // Lane mask for a width code
  // ==========================================================
  function automatic logic [7:0] cdo_lane_mask(input logic [1:0] w);
    logic [7:0] m;
    m = 8'h01;
    case (w)
      OPT_WIDTH_2: m = 8'h03;
      OPT_WIDTH_4: m = 8'h0f;
      OPT_WIDTH_8: m = 8'hff;
      default:     m = 8'h01;
    endcase
    return m;
  endfunction

  // Number of shift steps per word for a width code
  function automatic logic [3:0] cdo_steps(input logic [1:0] w);
    logic [3:0] s;
    s = 4'h8;
    case (w)
      OPT_WIDTH_2: s = 4'h4;
      OPT_WIDTH_4: s = 4'h2;
      OPT_WIDTH_8: s = 4'h1;
      default:     s = 4'h8;
    endcase
    return s;
  endfunction
endpackage

// ---- verilog/cdo_stream_if.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Valid/ready word stream between modules
// ==========================================================
interface cdo_stream_if #(parameter int WIDTH = 8);
  logic             valid;   // Word offered
  logic             ready;   // Word accepted
  logic [WIDTH-1:0] data;    // Word
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ---- verilog/cdo_unit.sv ----
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// R1: byte mode drives whole byte per clock
// R2: serial mode sends one bit on line 0
// R3: serial mode holds lines 7..1 low
// R4: n-chain mode drives n lines, rest low
// R5: each active line is its own bitstream
// R6: width comes from stored option, not pins
// R7: odd chain counts use next wider mode
// R8: targets pass chain enable down the chain
// R9: targets share one done line
// R10: any error pulls status low, restarts chain
// R11: start only with status high, done low
// R12: data steady around rising clock edge
// R13: clock stops while no data is ready
// R14: done missing after 64 clocks pulses status
// R15: mode held constant through a cycle
// R16: advance data only on toggling clocks
module cdo_unit
  import cdo_pkg::*;
#(
  parameter int WIDTH      = DATA_W,         // Data lines
  parameter int DEPTH      = FIFO_DEPTH,     // Buffer words
  parameter int DONE_WAIT  = DONE_WAIT_CLKS  // Done release timeout
) (
  input  wire logic             core_clk_in,      // Core clock, 100 MHz
  input  wire logic             rst_b_in,         // Sync reset, low
  input  wire logic             ce_in,            // Core clock enable
  input  wire logic             link_clk_in,      // Link clock
  input  wire logic             link_rst_b_in,    // Link reset, low
  input  wire logic             opt_byte_mode_in, // Stored option: byte parallel
  input  wire logic [1:0]       opt_width_in,     // Stored option: chain width code
  input  wire logic [WIDTH-1:0] word_in,          // Decompressed word
  input  wire logic             word_valid_in,    // Word offered
  output logic                  word_ready_out,   // Word accepted
  input  wire logic             last_word_in,     // Final word of image
  input  wire logic             status_in,        // Shared status line level
  output logic                  status_oe_out,    // Pull status line low
  output logic                  status_out,       // Driven level, always low
  input  wire logic             done_in,          // Shared done line level
  output logic                  config_clock_out, // Configuration clock
  output logic [WIDTH-1:0]      data_out,         // Data lines
  output logic                  busy_out          // Transfer in progress
);
  // ==========================================================
  // Core side: buffer fill and last marker
  // ==========================================================
  cdo_stream_if #(.WIDTH(WIDTH+1)) fill_s ();  // Word plus last flag
  cdo_stream_if #(.WIDTH(WIDTH+1)) drain_s (); // Link side

  assign fill_s.valid   = word_valid_in;
  assign fill_s.data    = {last_word_in, word_in};
  assign word_ready_out = fill_s.ready & ce_in;  // Back-pressure to source

  cdo_fifo #(.WIDTH(WIDTH+1), .DEPTH(DEPTH)) u_fifo (
    .wr_clk_in   (core_clk_in),
    .wr_rst_b_in (rst_b_in),
    .wr_ce_in    (ce_in),
    .rd_clk_in   (link_clk_in),
    .rd_rst_b_in (link_rst_b_in),
    .wr          (fill_s.snk),
    .rd          (drain_s.src)
  );

  // ==========================================================
  // Core side: report link activity
  // ==========================================================
  logic busy_link;                  // Link domain busy level
  logic busy_s1, busy_s2, busy_s3;  // Three-stage pin style sync

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      busy_s1  <= 1'b0;
      busy_s2  <= 1'b0;
      busy_s3  <= 1'b0;
      busy_out <= 1'b0;
    end else if (ce_in) begin
      busy_s1 <= busy_link;
      busy_s2 <= busy_s1;
      busy_s3 <= busy_s2;
      // Change counts once second and third agree
      if (busy_s2 == busy_s3) begin
        busy_out <= busy_s3;
      end
    end
  end

  // ==========================================================
  // Link side: pin synchronisers for shared lines
  // ==========================================================
  logic st_s1, st_s2, st_s3, st_q;  // Status line sync
  logic dn_s1, dn_s2, dn_s3, dn_q;  // Done line sync

  always_ff @(posedge link_clk_in) begin
    if (!link_rst_b_in) begin
      st_s1 <= 1'b0;
      st_s2 <= 1'b0;
      st_s3 <= 1'b0;
      st_q  <= 1'b0;
      dn_s1 <= 1'b0;
      dn_s2 <= 1'b0;
      dn_s3 <= 1'b0;
      dn_q  <= 1'b0;
    end else begin
      st_s1 <= status_in;
      st_s2 <= st_s1;
      st_s3 <= st_s2;
      dn_s1 <= done_in;
      dn_s2 <= dn_s1;
      dn_s3 <= dn_s2;
      if (st_s2 == st_s3) begin
        st_q <= st_s3;
      end
      if (dn_s2 == dn_s3) begin
        dn_q <= dn_s3;
      end
    end
  end

  // Static option straps into the link clock
  logic       opt_b_s1, opt_b_s2;   // Byte option sync
  logic [1:0] opt_w_s1, opt_w_s2;   // Width option sync

  always_ff @(posedge link_clk_in) begin
    if (!link_rst_b_in) begin
      opt_b_s1 <= 1'b0;
      opt_b_s2 <= 1'b0;
      opt_w_s1 <= OPT_WIDTH_1;
      opt_w_s2 <= OPT_WIDTH_1;
    end else begin
      opt_b_s1 <= opt_byte_mode_in;
      opt_b_s2 <= opt_b_s1;
      opt_w_s1 <= opt_width_in;
      opt_w_s2 <= opt_w_s1;
    end
  end

  // ==========================================================
  // Link side: state machine
  // ==========================================================
  typedef enum logic [2:0] {
    ST_WAIT,    // Waiting for targets ready
    ST_RUN,     // Shifting data
    ST_CHECK,   // Waiting for done release
    ST_ERROR,   // Pulling status low
    ST_FINISH   // Configured, idle
  } cdo_state_e;

  cdo_state_e state;               // Current state
  cdo_mode_e  mode;                // Latched mode
  logic [1:0] width;               // Latched width code
  logic [7:0] shreg;               // Word being shifted
  logic [3:0] steps;               // Shift steps left in word
  logic       have_word;           // Shift register loaded
  logic       last_flag;           // Current word is the last
  logic       clk_phase;           // Config clock level
  logic [6:0] wait_cnt;            // Done timeout counter
  logic [2:0] err_cnt;             // Error pulse length
  logic [7:0] lanes;               // Lane mask for width

  assign lanes     = cdo_lane_mask(width);
  assign busy_link = (state == ST_RUN) || (state == ST_CHECK);

  // Next word once the current one is spent; none taken on error
  assign drain_s.ready = (state == ST_RUN) && st_q && (!have_word ||
                         (clk_phase && steps == 4'h1 && !last_flag));

  // Mode latch at entry to transfer
  always_ff @(posedge link_clk_in) begin
    if (!link_rst_b_in) begin
      mode  <= CDO_MODE_SERIAL;
      width <= OPT_WIDTH_1;
    end else if (state == ST_WAIT) begin
      // Width taken from stored option; held until restart [R6] [R15]
      mode  <= (opt_b_s2 == OPT_MODE_BYTE) ? CDO_MODE_BYTE : CDO_MODE_SERIAL;
      width <= opt_w_s2;
    end
  end

  // Sequencer
  always_ff @(posedge link_clk_in) begin
    if (!link_rst_b_in) begin
      state     <= ST_WAIT;
      have_word <= 1'b0;
      last_flag <= 1'b0;
      shreg     <= 8'h00;
      steps     <= 4'h0;
      clk_phase <= 1'b0;
      wait_cnt  <= 7'h00;
      err_cnt   <= 3'h0;
    end else begin
      case (state)
        ST_WAIT: begin
          clk_phase <= 1'b0;
          have_word <= 1'b0;
          if (st_q && !dn_q) begin  // [R11]
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!st_q) begin
            // Target error: stop [R10]
            state     <= ST_WAIT;
            clk_phase <= 1'b0;
          end else if (drain_s.valid && drain_s.ready) begin
            // Load; clock low so data settles [R12]
            shreg     <= drain_s.data[7:0];
            last_flag <= drain_s.data[WIDTH];
            steps     <= (mode == CDO_MODE_BYTE) ? 4'h1 : cdo_steps(width);
            have_word <= 1'b1;
            clk_phase <= 1'b0;
          end else if (have_word && !clk_phase) begin
            clk_phase <= 1'b1;  // Rise; data already stable [R12]
          end else if (have_word && clk_phase) begin
            clk_phase <= 1'b0;
            if (steps == 4'h1) begin
              have_word <= 1'b0;  // Clock held low until next word [R13]
              if (last_flag) begin
                state    <= ST_CHECK;
                wait_cnt <= 7'h00;
              end
            end else begin
              // Shift after a full clock [R16]
              steps <= steps - 4'h1;
              case (width)
                OPT_WIDTH_2: shreg <= {2'h0, shreg[7:2]};
                OPT_WIDTH_4: shreg <= {4'h0, shreg[7:4]};
                default:     shreg <= {1'b0, shreg[7:1]};
              endcase
            end
          end
        end
        ST_CHECK: begin
          // Keep clocking while waiting for done [R14]
          clk_phase <= ~clk_phase & st_q & ~dn_q;
          if (dn_q) begin
            state <= ST_FINISH;
          end else if (!st_q) begin
            state <= ST_WAIT;  // [R10]
          end else if (clk_phase) begin
            if (wait_cnt == 7'(DONE_WAIT - 1)) begin
              state   <= ST_ERROR;  // [R14]
              err_cnt <= 3'h0;
            end else begin
              wait_cnt <= wait_cnt + 7'h01;
            end
          end
        end
        ST_ERROR: begin
          clk_phase <= 1'b0;
          err_cnt   <= err_cnt + 3'h1;
          if (err_cnt == 3'(ERR_PULSE_CLKS - 1)) begin
            state <= ST_WAIT;  // Restart whole chain [R10]
          end
        end
        ST_FINISH: begin
          clk_phase <= 1'b0;
          if (!st_q) begin
            state <= ST_WAIT;  // Reconfiguration requested
          end
        end
        default: state <= ST_WAIT;
      endcase
    end
  end

  // ==========================================================
  // Link side: pin drivers, registered
  // ==========================================================
  always_ff @(posedge link_clk_in) begin
    if (!link_rst_b_in) begin
      data_out         <= '0;
      config_clock_out <= 1'b0;
      status_oe_out    <= 1'b0;
    end else begin
      config_clock_out <= clk_phase;  // Toggles with data, and in ST_CHECK while done is awaited [R13]
      status_oe_out    <= (state == ST_ERROR);  // Open drain pull low [R10] [R14]
      if (state == ST_FINISH) begin
        data_out <= IDLE_DATA;
      end else if (mode == CDO_MODE_BYTE) begin
        data_out <= shreg;  // Whole byte [R1]
      end else begin
        // Lane i gets bit i; upper lanes low [R2] [R3] [R4] [R5]
        data_out <= shreg & lanes;
      end
    end
  end

  assign status_out = 1'b0;
endmodule
`default_nettype wire
